// ==== logic/p3s_allow_ctr.sv ====
// per-queue packet allowance counter
// assumes reload and take are never high together
`timescale 1ns/10ps
`include "p3s_cfg.svh"
module p3s_allow_ctr #(
    parameter p3s_pkg::p3s_ratio_t RST_CNT = 7'h01
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // control
    input wire logic i_reload,
    input wire p3s_pkg::p3s_ratio_t i_ratio,
    input wire logic i_take,
    // state
    output p3s_pkg::p3s_ratio_t o_count
);
    import p3s_pkg::*;

    p3s_ratio_t cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (i_reload) begin
            cnt_d = i_ratio;
        end else if (i_take && cnt_q != 7'h00) begin
            cnt_d = cnt_q - 7'h01;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= RST_CNT;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_count = cnt_q;
endmodule // p3s_allow_ctr

// ==== logic/p3s_cfg.svh ====
// offsets, field positions, reset values for the port 3 queue scheduler
// included by the scheduler and its counter; definitions only
`ifndef P3S_CFG_SVH
`define P3S_CFG_SVH

`define P3S_ADDR_W 12
`define P3S_OFF_HI 12'h0d0
`define P3S_OFF_LO 12'h0d2
`define P3S_OFF_STAT 12'h0f0

`define P3S_CTL_UP 15
`define P3S_CTL_DN 7
`define P3S_RAT_UP_MSB 14
`define P3S_RAT_UP_LSB 8
`define P3S_RAT_DN_MSB 6
`define P3S_RAT_DN_LSB 0

`define P3S_Q0_RATIO_RST 7'h01
`define P3S_Q1_RATIO_RST 7'h02
`define P3S_Q2_RATIO_RST 7'h04
`define P3S_Q3_RATIO_RST 7'h08
`define P3S_CTL_RST 1'b1
`define P3S_HI_RST {`P3S_CTL_RST, `P3S_Q2_RATIO_RST, `P3S_CTL_RST, `P3S_Q3_RATIO_RST}
`define P3S_LO_RST {`P3S_CTL_RST, `P3S_Q0_RATIO_RST, `P3S_CTL_RST, `P3S_Q1_RATIO_RST}

`endif

// ==== logic/p3s_pkg.sv ====
// types shared by the port 3 queue scheduler files
// no assumptions beyond a systemverilog compiler
package p3s_pkg;
    typedef logic [6:0] p3s_ratio_t;
    typedef logic [1:0] p3s_qid_t;
    typedef logic [15:0] p3s_word_t;
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_WAIT
    } p3s_state_t;
endpackage

// ==== logic/p3s_scheduler.sv ====
// port 3 transmit queue scheduler with two ratio control registers
// assumes queue status and tx done come from logic on i_ref_clk
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "p3s_cfg.svh"
module p3s_scheduler (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [`P3S_ADDR_W-1:0] i_reg_addr,
    input wire p3s_pkg::p3s_word_t i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output p3s_pkg::p3s_word_t o_reg_rdata,
    // queue status from the switch
    input wire logic [3:0] i_q_pkt_avail,
    // transmit mac handshake
    input wire logic i_tx_done,
    output logic o_grant_vld,
    output p3s_pkg::p3s_qid_t o_grant_qid
);
    import p3s_pkg::*;

    default clocking cb @(posedge i_ref_clk);
    endclocking

    default disable iff (!i_arst_n);

    localparam p3s_ratio_t RST_RATIO [4] = '{
        `P3S_Q0_RATIO_RST,
        `P3S_Q1_RATIO_RST,
        `P3S_Q2_RATIO_RST,
        `P3S_Q3_RATIO_RST
    };

    p3s_word_t hi_q, hi_d;
    p3s_word_t lo_q, lo_d;
    p3s_word_t rdata_q, rdata_d;
    p3s_state_t st_q, st_d;
    logic gv_q, gv_d;
    p3s_qid_t gq_q, gq_d;
    logic [3:0] ratio_mode;
    p3s_ratio_t ratio [4];
    p3s_ratio_t cnt [4];
    logic [3:0] elig;
    logic [3:0] take;
    p3s_qid_t pick;
    logic grant_now;
    logic reload;

    // field mapping: high register holds q2/q3, low register q0/q1
    always_comb begin
        ratio_mode[3] = hi_q[`P3S_CTL_DN];
        ratio_mode[2] = hi_q[`P3S_CTL_UP];
        ratio_mode[1] = lo_q[`P3S_CTL_DN];
        ratio_mode[0] = lo_q[`P3S_CTL_UP];
        ratio[3] = hi_q[`P3S_RAT_DN_MSB:`P3S_RAT_DN_LSB];
        ratio[2] = hi_q[`P3S_RAT_UP_MSB:`P3S_RAT_UP_LSB];
        ratio[1] = lo_q[`P3S_RAT_DN_MSB:`P3S_RAT_DN_LSB];
        ratio[0] = lo_q[`P3S_RAT_UP_MSB:`P3S_RAT_UP_LSB];
    end

    // registers and read port
    always_comb begin
        hi_d = hi_q;
        lo_d = lo_q;
        rdata_d = 16'h0000;
        if (i_reg_wr) begin
            if (i_reg_addr == `P3S_OFF_HI) begin
                hi_d = i_reg_wdata;
            end else if (i_reg_addr == `P3S_OFF_LO) begin
                lo_d = i_reg_wdata;
            end
        end
        if (i_reg_rd) begin
            if (i_reg_addr == `P3S_OFF_HI) begin
                rdata_d = hi_q;
            end else if (i_reg_addr == `P3S_OFF_LO) begin
                rdata_d = lo_q;
            end else if (i_reg_addr == `P3S_OFF_STAT) begin
                rdata_d = {9'h000, st_q == ST_WAIT, gq_q, elig};
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hi_q <= `P3S_HI_RST;
            lo_q <= `P3S_LO_RST;
            rdata_q <= 16'h0000;
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
            rdata_q <= rdata_d;
        end
    end

    // a ratio queue with a zero field is not eligible once a reload has set its count to zero
    genvar q;
    generate
        for (q = 0; q < 4; q = q + 1) begin : g_queue
            assign elig[q] = i_q_pkt_avail[q] && (!ratio_mode[q] || cnt[q] != 7'h00);
            assign take[q] = grant_now && pick == 2'(q) && ratio_mode[q];
            p3s_allow_ctr #(
                .RST_CNT(RST_RATIO[q])
            ) u_ctr (
                .i_ref_clk(i_ref_clk),
                .i_arst_n(i_arst_n),
                .i_reload(reload),
                .i_ratio(ratio[q]),
                .i_take(take[q]),
                .o_count(cnt[q])
            );
        end
    endgenerate

    always_comb begin
        pick = 2'h0;
        if (elig[3]) begin
            pick = 2'h3;
        end else if (elig[2]) begin
            pick = 2'h2;
        end else if (elig[1]) begin
            pick = 2'h1;
        end
    end

    assign grant_now = st_q == ST_IDLE && |elig;
    assign reload = st_q == ST_IDLE && !(|elig);

    // one packet in flight; the next pick waits for tx done
    always_comb begin
        st_d = st_q;
        gv_d = 1'b0;
        gq_d = gq_q;
        unique case (st_q)
            ST_IDLE: begin
                if (grant_now) begin
                    gv_d = 1'b1;
                    gq_d = pick;
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (i_tx_done) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= ST_IDLE;
            gv_q <= 1'b0;
            gq_q <= 2'h0;
        end else begin
            st_q <= st_d;
            gv_q <= gv_d;
            gq_q <= gq_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_grant_vld = gv_q;
    assign o_grant_qid = gq_q;

    // checks
    logic seen_q;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    sequence s_grant(p3s_qid_t qid);
        o_grant_vld && o_grant_qid == qid ##1 !o_grant_vld;
    endsequence

    sequence s_idle_pick;
        st_q == ST_IDLE && |elig;
    endsequence

    AST_Q2_STRICT: assert property (
        s_idle_pick and (i_q_pkt_avail[2] && !ratio_mode[2] && !elig[3]) |=> s_grant(2'h2)
    ) else $error("strict queue 2 not served first");

    AST_Q2_LIMIT: assert property (
        take[2] |-> cnt[2] != 7'h00 ##1 cnt[2] == $past(cnt[2]) - 7'h01
    ) else $error("queue 2 allowance not spent correctly");

    AST_Q3_STRICT: assert property (
        s_idle_pick and (i_q_pkt_avail[3] && !ratio_mode[3]) |=> s_grant(2'h3)
    ) else $error("strict queue 3 not served first");

    AST_Q3_LIMIT: assert property (
        (o_grant_vld && o_grant_qid == 2'h3 && $past(ratio_mode[3]))
            |-> $past(cnt[3]) != 7'h00
    ) else $error("queue 3 sent beyond its allowance");

    AST_Q0_LAST: assert property (
        (o_grant_vld && o_grant_qid == 2'h0) |-> $past(elig[3:1]) == 3'h0
    ) else $error("queue 0 sent while a higher queue was eligible");

    AST_Q0_LIMIT: assert property (
        take[0] |=> cnt[0] == $past(cnt[0]) - 7'h01
    ) else $error("queue 0 allowance not decremented");

    AST_Q1_STRICT: assert property (
        s_idle_pick and (i_q_pkt_avail[1] && !ratio_mode[1] && elig[3:2] == 2'h0)
            |=> s_grant(2'h1)
    ) else $error("strict queue 1 not served before queue 0");

    AST_Q1_LIMIT: assert property (
        (i_q_pkt_avail[1] && ratio_mode[1] && cnt[1] == 7'h00 && st_q == ST_IDLE)
            |=> !(o_grant_vld && o_grant_qid == 2'h1)
    ) else $error("queue 1 sent with no allowance left");

    AST_RST_MODE: assert property (
        !seen_q |-> hi_q == `P3S_HI_RST && lo_q == `P3S_LO_RST && cnt[0] == `P3S_Q0_RATIO_RST
    ) else $error("control registers not at reset values");

    AST_RELOAD: assert property (
        reload |=> cnt[3] == $past(ratio[3]) && cnt[2] == $past(ratio[2])
            && cnt[1] == $past(ratio[1]) && cnt[0] == $past(ratio[0])
    ) else $error("allowances not reloaded at period start");

    AST_REG_WR: assert property (
        (i_reg_wr && i_reg_addr == `P3S_OFF_HI) ##1 (i_reg_rd && i_reg_addr == `P3S_OFF_HI)
            |=> o_reg_rdata == $past(i_reg_wdata, 2)
    ) else $error("high register write not read back");

    AST_RD_ONE: assert property (
        !$past(i_reg_rd) |-> o_reg_rdata == 16'h0000
    ) else $error("read data outside its cycle");

    AST_ONE_FLIGHT: assert property (
        o_grant_vld |=> !o_grant_vld throughout (st_q == ST_WAIT [*2])
    ) else $error("second grant before tx done");

    AST_Q2_BLOCK: assert property (
        (i_q_pkt_avail[2] && ratio_mode[2] && cnt[2] == 7'h00 && st_q == ST_IDLE)
            |=> !(o_grant_vld && o_grant_qid == 2'h2)
    ) else $error("queue 2 sent with no allowance left");

    AST_Q3_BLOCK: assert property (
        (i_q_pkt_avail[3] && ratio_mode[3] && cnt[3] == 7'h00 && st_q == ST_IDLE)
            |=> !(o_grant_vld && o_grant_qid == 2'h3)
    ) else $error("queue 3 sent with no allowance left");

    AST_Q3_SPEND: assert property (
        take[3] |=> cnt[3] == $past(cnt[3]) - 7'h01
    ) else $error("queue 3 allowance not decremented");

    AST_Q0_STRICT: assert property (
        s_idle_pick and (i_q_pkt_avail[0] && !ratio_mode[0] && elig[3:1] == 3'h0)
            |=> s_grant(2'h0)
    ) else $error("strict queue 0 not served once higher queues idle");

    AST_Q0_BLOCK: assert property (
        (i_q_pkt_avail[0] && ratio_mode[0] && cnt[0] == 7'h00 && st_q == ST_IDLE)
            |=> !(o_grant_vld && o_grant_qid == 2'h0)
    ) else $error("queue 0 sent with no allowance left");

    AST_Q1_SPEND: assert property (
        take[1] |=> cnt[1] == $past(cnt[1]) - 7'h01
    ) else $error("queue 1 allowance not decremented");

    AST_RST_IDLE: assert property (
        !seen_q |-> !o_grant_vld && o_reg_rdata == 16'h0000 && cnt[3] == `P3S_Q3_RATIO_RST
            && cnt[2] == `P3S_Q2_RATIO_RST && cnt[1] == `P3S_Q1_RATIO_RST
    ) else $error("outputs or allowances not at reset values");

    AST_REG_WR_LO: assert property (
        (i_reg_wr && i_reg_addr == `P3S_OFF_LO) ##1 (i_reg_rd && i_reg_addr == `P3S_OFF_LO)
            |=> o_reg_rdata == $past(i_reg_wdata, 2)
    ) else $error("low register write not read back");

    AST_REG_KEEP: assert property (
        !(i_reg_wr && (i_reg_addr == `P3S_OFF_HI || i_reg_addr == `P3S_OFF_LO))
            |=> $stable(hi_q) && $stable(lo_q)
    ) else $error("control register changed without a write");

    AST_RD_HI: assert property (
        (i_reg_rd && i_reg_addr == `P3S_OFF_HI) |=> o_reg_rdata == $past(hi_q)
    ) else $error("high register read data wrong");

    AST_RD_LO: assert property (
        (i_reg_rd && i_reg_addr == `P3S_OFF_LO) |=> o_reg_rdata == $past(lo_q)
    ) else $error("low register read data wrong");
endmodule // p3s_scheduler

// ==== sim/p3s_mac_model.sv ====
// port 3 transmit mac model: holds queue depths, answers each grant with tx done
// assumes grants arrive one at a time, same clock as the scheduler
`timescale 1ns/10ps
module p3s_mac_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // bench control
    input wire logic i_load,
    input wire logic i_slow,
    input wire logic [31:0] i_depths,
    // scheduler side
    input wire logic i_grant_vld,
    input wire p3s_pkg::p3s_qid_t i_grant_qid,
    output logic [3:0] o_q_pkt_avail,
    output logic o_tx_done
);
    logic [7:0] cnt_q [4];
    logic [3:0] wait_q;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int q = 0; q < 4; q++) cnt_q[q] <= 8'h00;
            wait_q <= 4'h0;
            o_tx_done <= 1'b0;
        end else begin
            o_tx_done <= 1'b0;
            if (i_load) begin
                for (int q = 0; q < 4; q++) cnt_q[q] <= i_depths[8*q +: 8];
            end
            // avail drops at once, well before done frees the scheduler
            if (i_grant_vld) begin
                cnt_q[i_grant_qid] <= cnt_q[i_grant_qid] - 8'h01;
                wait_q <= i_slow ? 4'h5 : 4'h1;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
                o_tx_done <= (wait_q == 4'h1);
            end
        end
    end
    always_comb begin
        for (int q = 0; q < 4; q++) o_q_pkt_avail[q] = (cnt_q[q] != 8'h00);
    end
endmodule // p3s_mac_model

// ==== sim/test_port3_txq_ratio_scheduler.sv ====
// bench for the port 3 queue scheduler: register access and grant order
// assumes the mac model in p3s_mac_model.sv
`timescale 1ns/10ps
`include "p3s_cfg.svh"
module test_port3_txq_ratio_scheduler;
    import p3s_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [`P3S_ADDR_W-1:0] addr = '0;
    p3s_word_t wdata = '0;
    p3s_word_t rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic load = 1'b0;
    logic slow = 1'b0;
    logic [31:0] deps = '0;
    logic [3:0] avail;
    logic done;
    logic gvld;
    p3s_qid_t qid;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    p3s_scheduler DUT (.i_ref_clk(clk), .i_arst_n(arst_n), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_q_pkt_avail(avail), .i_tx_done(done), .o_grant_vld(gvld), .o_grant_qid(qid));
    p3s_mac_model MAC (.i_ref_clk(clk), .i_arst_n(arst_n), .i_load(load), .i_slow(slow),
        .i_depths(deps), .i_grant_vld(gvld), .i_grant_qid(qid), .o_q_pkt_avail(avail),
        .o_tx_done(done));
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input p3s_word_t d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input p3s_word_t e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("reg_rdata", e, rdata);
    endtask
    // write then read back in the very next cycle, no gap between strobes
    task automatic wr_rd_chk(input logic [11:0] a, input p3s_word_t d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("reg_rdata", d, rdata);
    endtask
    // load queues, compare the first n grants (msb pair first), then drain
    task automatic run(input logic [31:0] d, input logic [31:0] e, input int n, input logic s);
        int k;
        k = 0;
        @(posedge clk);
        load <= 1'b1; deps <= d; slow <= s;
        @(posedge clk);
        load <= 1'b0;
        for (int t = 0; t < 3000 && (k < n || avail !== 4'h0); t++) begin
            @(posedge clk);
            #1;
            if (gvld === 1'b1 && k < n) begin
                chk("grant_qid", {14'h0, e[31-2*k -: 2]}, {14'h0, qid});
                k++;
            end
        end
        chk("grant_count", n[15:0], k[15:0]);
        // a drain that never finishes counts as a mismatch
        chk("drain_avail", 16'h0000, {12'h000, avail});
        repeat (12) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(`P3S_OFF_HI, 16'h8488);
        rd_chk(`P3S_OFF_LO, 16'h8182);
        run(32'h09050302, 32'hffffaa53, 16, 1'b0);
        wr_reg(`P3S_OFF_HI, 16'h0488);
        run(32'h02060303, 32'hfaaa5100, 14, 1'b1);
        wr_reg(`P3S_OFF_HI, 16'h0000);
        wr_reg(`P3S_OFF_LO, 16'h0000);
        run(32'h02020202, 32'hfa500000, 8, 1'b0);
        wr_rd_chk(`P3S_OFF_HI, 16'h8183);
        wr_rd_chk(`P3S_OFF_LO, 16'h8281);
        wr_reg(12'h0d4, 16'hffff);
        rd_chk(12'h0d4, 16'h0000);
        run(32'h04040404, 32'hfe439000, 12, 1'b1);
        // idle, last grant to queue 1, nothing eligible
        rd_chk(`P3S_OFF_STAT, 16'h0010);
        stop_test();
    end
endmodule // test_port3_txq_ratio_scheduler
